// file: hw/tts_defines.svh
// What this block does
// - Immediate trigger fires an initiated channel whatever source is selected.
// - Bus source accepts device trigger, common trigger or group execute trigger.
// - Pin source takes its trigger from the digital pin named in the setting.
// - Channel source takes the trigger-out event of the named channel.
// - Source selection is held per channel; commands name target channels.
// - After reset every channel trigger state machine is idle.
// - An idle channel ignores every trigger event.
// - Initiate moves each addressed channel from idle to initiated.
// - Accepted trigger loads the programmed trigger levels into the outputs.
// - After the triggered action the channel returns idle; re-initiate needed.
// - Pin or channel source waits without time limit for its event.
// - Abort returns addressed channels to idle, ending any wait.
// - Step mode applies triggered value; fixed mode ignores it.
// - Trigger-out enabled channel emits an event when its step occurs.
`ifndef TTS_DEFINES_SVH
`define TTS_DEFINES_SVH

`define TTS_NCH 4
`define TTS_NPIN 7
`define TTS_AW 6
`define TTS_DW 32

// Byte offsets on the register bus
`define TTS_OFS_CMD 6'h00
`define TTS_OFS_STATUS 6'h04
`define TTS_GRP_CFG 2'h1
`define TTS_GRP_LVL 2'h2

// Address fields: register group, then channel within the group
`define TTS_ADR_GRP_MSB 5
`define TTS_ADR_GRP_LSB 4
`define TTS_ADR_SEL_MSB 3
`define TTS_ADR_SEL_LSB 2
`define TTS_CHAN_IDX_MSB 1

// Command register fields
`define TTS_CMD_MASK_LSB 0
`define TTS_CMD_MASK_MSB 3
`define TTS_CMD_OP_LSB 4
`define TTS_CMD_OP_MSB 6
`define TTS_OP_INIT 3'h1
`define TTS_OP_ABORT 3'h2
`define TTS_OP_IMM 3'h3
`define TTS_OP_BUS 3'h4

`define TTS_CFG_MSB 7
`define TTS_CFG_RST 8'h00
`define TTS_LVL_RST 32'h0000_0000
`define TTS_ZERO 32'h0000_0000

`endif

// file: hw/tts_pkg.sv
`include "tts_defines.svh"

package tts_pkg;

  typedef enum logic [1:0] {
    TTS_SRC_BUS,
    TTS_SRC_PIN,
    TTS_SRC_CHAN
  } tts_src_t;

  typedef enum logic [1:0] {
    TTS_ST_IDLE,
    TTS_ST_INIT,
    TTS_ST_ACT
  } tts_state_t;

  typedef struct packed {
    logic trig_out_en;
    logic curr_step;
    logic volt_step;
    logic [2:0] idx;
    tts_src_t src;
  } tts_cfg_t;

  typedef struct packed {
    logic [15:0] curr;
    logic [15:0] volt;
  } tts_level_t;

endpackage : tts_pkg

// file: hw/tts_top.sv
// Implementation choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ns
`include "tts_defines.svh"

module tts_top
  import tts_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [`TTS_AW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [`TTS_DW-1:0] avs_writedata_i,
  output logic [`TTS_DW-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [`TTS_NPIN-1:0] dig_pin_i,
  input wire logic [`TTS_NCH-1:0] fp_imm_trig_i,
  output tts_level_t [`TTS_NCH-1:0] level_o,
  output logic [`TTS_NCH-1:0] initiated_o,
  output logic [`TTS_NCH-1:0] trigger_output_pin_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic rst_meta_r;
  logic rst_n_r;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and rising edge detect

  logic [`TTS_NPIN-1:0] pin_meta_r;
  logic [`TTS_NPIN-1:0] pin_sync_r;
  logic [`TTS_NPIN-1:0] pin_prev_r;
  logic [`TTS_NPIN-1:0] pin_rise;
  logic [`TTS_NCH-1:0] fp_meta_r;
  logic [`TTS_NCH-1:0] fp_sync_r;
  logic [`TTS_NCH-1:0] fp_prev_r;
  logic [`TTS_NCH-1:0] fp_rise;

  always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
      pin_prev_r <= '0;
      fp_meta_r <= '0;
      fp_sync_r <= '0;
      fp_prev_r <= '0;
    end else begin
      pin_meta_r <= dig_pin_i;
      pin_sync_r <= pin_meta_r;
      pin_prev_r <= pin_sync_r;
      fp_meta_r <= fp_imm_trig_i;
      fp_sync_r <= fp_meta_r;
      fp_prev_r <= fp_sync_r;
    end
  end

  // A held-high pin fires once; only a fresh edge counts as an event
  assign pin_rise = pin_sync_r & ~pin_prev_r;
  assign fp_rise = fp_sync_r & ~fp_prev_r;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait state, answer on the second edge

  logic wait_r;
  logic [`TTS_DW-1:0] rdata_r;
  logic req;
  logic take;
  logic [1:0] grp;
  logic [1:0] sel;
  tts_cfg_t cfg_r [`TTS_NCH];
  tts_level_t lvl_r [`TTS_NCH];
  tts_state_t state_r [`TTS_NCH];
  logic [`TTS_NCH-1:0] cmd_init_r;
  logic [`TTS_NCH-1:0] cmd_abort_r;
  logic [`TTS_NCH-1:0] cmd_imm_r;
  logic [`TTS_NCH-1:0] cmd_bus_r;
  logic [`TTS_NCH-1:0] busy;
  logic [`TTS_NCH-1:0] cmd_mask;
  logic [2:0] cmd_op;

  assign req = avs_read_i | avs_write_i;
  assign take = req & ~wait_r;
  assign grp = avs_address_i[`TTS_ADR_GRP_MSB:`TTS_ADR_GRP_LSB];
  assign sel = avs_address_i[`TTS_ADR_SEL_MSB:`TTS_ADR_SEL_LSB];
  assign cmd_mask = avs_writedata_i[`TTS_CMD_MASK_MSB:`TTS_CMD_MASK_LSB];
  assign cmd_op = avs_writedata_i[`TTS_CMD_OP_MSB:`TTS_CMD_OP_LSB];

  always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= ~(req & wait_r);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rdata_r <= `TTS_ZERO;
    end else if (avs_read_i && wait_r) begin
      rdata_r <= `TTS_ZERO;
      if (avs_address_i == `TTS_OFS_STATUS) begin
        rdata_r[`TTS_NCH-1:0] <= busy;
      end else if (grp == `TTS_GRP_CFG) begin
        rdata_r[`TTS_CFG_MSB:0] <= cfg_r[sel];
      end else if (grp == `TTS_GRP_LVL) begin
        rdata_r <= lvl_r[sel];
      end
    end
  end

  // Per channel configuration and trigger levels
  always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      for (int i = 0; i < `TTS_NCH; i++) begin
        cfg_r[i] <= tts_cfg_t'(`TTS_CFG_RST);
        lvl_r[i] <= tts_level_t'(`TTS_LVL_RST);
      end
    end else if (take && avs_write_i) begin
      if (grp == `TTS_GRP_CFG) begin
        cfg_r[sel] <= tts_cfg_t'(avs_writedata_i[`TTS_CFG_MSB:0]);
      end else if (grp == `TTS_GRP_LVL) begin
        lvl_r[sel] <= tts_level_t'(avs_writedata_i);
      end
    end
  end

  // Commands become one-cycle pulses on the masked channels
  always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cmd_init_r <= '0;
      cmd_abort_r <= '0;
      cmd_imm_r <= '0;
      cmd_bus_r <= '0;
    end else begin
      cmd_init_r <= '0;
      cmd_abort_r <= '0;
      cmd_imm_r <= '0;
      cmd_bus_r <= '0;
      if (take && avs_write_i && avs_address_i == `TTS_OFS_CMD) begin
        case (cmd_op)
          `TTS_OP_INIT: cmd_init_r <= cmd_mask;
          `TTS_OP_ABORT: cmd_abort_r <= cmd_mask;
          `TTS_OP_IMM: cmd_imm_r <= cmd_mask;
          `TTS_OP_BUS: cmd_bus_r <= cmd_mask;
          default: cmd_init_r <= '0;
        endcase
      end
    end
  end

  assign avs_readdata_o = rdata_r;
  assign avs_waitrequest_o = wait_r;

  ////////////////////////////////////////////////////////////////////////////
  // Per channel trigger sequencer

  logic [`TTS_NCH-1:0] trigger_output_pin_r;
  logic [`TTS_NCH-1:0] init_r;
  tts_level_t [`TTS_NCH-1:0] out_r;

  generate
    for (genvar ch = 0; ch < `TTS_NCH; ch++) begin : g_ch
      logic src_evt;
      logic trig;

      // Pin and channel sources have no timeout: only abort or an immediate trigger ends the wait
      always_comb begin
        case (cfg_r[ch].src)
          TTS_SRC_BUS: src_evt = cmd_bus_r[ch];
          TTS_SRC_PIN: src_evt = (cfg_r[ch].idx < 3'(`TTS_NPIN)) &&
            pin_rise[cfg_r[ch].idx];
          TTS_SRC_CHAN: src_evt = (cfg_r[ch].idx < 3'(`TTS_NCH)) &&
            trigger_output_pin_r[cfg_r[ch].idx[`TTS_CHAN_IDX_MSB:0]];
          default: src_evt = 1'b0;
        endcase
      end

      assign trig = src_evt | cmd_imm_r[ch] | fp_rise[ch];

      always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
          state_r[ch] <= TTS_ST_IDLE;
        end else if (cmd_abort_r[ch]) begin
          state_r[ch] <= TTS_ST_IDLE;
        end else begin
          case (state_r[ch])
            TTS_ST_IDLE: begin
              // Triggers here are dropped
              if (cmd_init_r[ch]) begin
                state_r[ch] <= TTS_ST_INIT;
              end
            end
            TTS_ST_INIT: begin
              // A repeated initiate only keeps the wait, it is not a trigger
              if (trig) begin
                state_r[ch] <= TTS_ST_ACT;
              end else if (cmd_init_r[ch]) begin
                state_r[ch] <= TTS_ST_INIT;
              end
            end
            TTS_ST_ACT: state_r[ch] <= TTS_ST_IDLE;
            default: state_r[ch] <= TTS_ST_IDLE;
          endcase
        end
      end

      // Levels change only on the action cycle, per function step mode
      always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
          out_r[ch] <= tts_level_t'(`TTS_LVL_RST);
        end else if (state_r[ch] == TTS_ST_ACT) begin
          if (cfg_r[ch].volt_step) begin
            out_r[ch].volt <= lvl_r[ch].volt;
          end
          if (cfg_r[ch].curr_step) begin
            out_r[ch].curr <= lvl_r[ch].curr;
          end
        end
      end

      always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
          trigger_output_pin_r[ch] <= 1'b0;
          init_r[ch] <= 1'b0;
        end else begin
          trigger_output_pin_r[ch] <= (state_r[ch] == TTS_ST_ACT) && cfg_r[ch].trig_out_en &&
            (cfg_r[ch].volt_step || cfg_r[ch].curr_step);
          init_r[ch] <= (state_r[ch] != TTS_ST_IDLE) && !cmd_abort_r[ch];
        end
      end

      assign busy[ch] = state_r[ch] != TTS_ST_IDLE;
    end
  endgenerate

  assign level_o = out_r;
  assign initiated_o = init_r;
  assign trigger_output_pin_o = trigger_output_pin_r;

endmodule : tts_top

// file: test/tts_pin_model.sv
`timescale 1ns/1ns
module tts_pin_model (
  input wire logic clk_i,
  input wire logic fire_i,
  input wire logic [2:0] idx_i,
  output logic [6:0] pin_o
);
  logic [3:0] cnt_r = 4'h0;
  logic [2:0] idx_r = 3'h0;
  // Held long enough to pass the input synchroniser, then back to low
  always_ff @(posedge clk_i) begin
    if (fire_i) begin
      cnt_r <= 4'h6;
      idx_r <= idx_i;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
  assign pin_o = (cnt_r != 4'h0) ? 7'h01 << idx_r : 7'h00;
endmodule : tts_pin_model

// file: test/tts_props.sv
`timescale 1ns/1ns
`include "tts_defines.svh"
module tts_props
  import tts_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire tts_level_t [3:0] level_o,
  input wire logic [3:0] initiated_o,
  input wire logic [3:0] trigger_output_pin_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence req_s;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence cmd_rd_s;
    avs_read_i && !avs_waitrequest_o && avs_address_i == `TTS_OFS_CMD;
  endsequence
  sequence back_idle_s;
    initiated_o[0] ##1 !initiated_o[0];
  endsequence
  one_wait_a: assert property (req_s |=> !avs_waitrequest_o)
    else $error("late answer");
  wait_short_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("long answer");
  cmd_read_a: assert property (cmd_rd_s |-> avs_readdata_o == '0)
    else $error("command read not zero");
  reset_idle_a: assert property (
    $rose(rst_b_i) |-> initiated_o == '0 ##1 initiated_o == '0) else $error("not idle");
  trig_idle_a: assert property (
    trigger_output_pin_o[0] |-> back_idle_s) else $error("no return to idle");
  step_cause_a: assert property (
    $changed(level_o[0]) |-> $past(initiated_o[0]) ##0 back_idle_s) else $error("stray step");
  init_cause_a: assert property (
    $rose(initiated_o[0]) |-> $past(avs_write_i, 3)) else $error("stray initiate");
  pulse_one_a: assert property (
    trigger_output_pin_o[0] |=> !trigger_output_pin_o[0] [*3]) else $error("long pulse");
endmodule : tts_props
bind tts_top tts_props u_tts_props (.ref_clk_i, .rst_b_i, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .level_o, .initiated_o,
  .trigger_output_pin_o);

// file: test/transient_trigger_sequencer_test.sv
`timescale 1ns/1ns
`include "tts_defines.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module transient_trigger_sequencer_test
  import tts_pkg::*;
;
  logic ref_clk_i = 1'h0, rst_b_i = 1'h0, rd = 1'h0, wr = 1'h0, wq, fire = 1'h0;
  logic [5:0] adr = '0;
  logic [31:0] wd = '0, rdat, rq = '0, seed = 32'hd601_23a9;
  logic [3:0] tseen = '0;
  logic [7:0] tc0 = '0;
  logic [2:0] fidx = '0;
  logic [3:0] fp = '0, ini, trigger_output_pin;
  logic [6:0] pin;
  tts_level_t [3:0] lv;
  tts_level_t ex [4];
  logic [31:0] pl [4];
  // Ch0 bus with trigger out, ch1 bus fixed, ch2 follows ch0, ch3 pin 5
  logic [31:0] cf = 32'h3542_00e0;
  int fails = 0, n_checks = 0, cyc = 0;
  tts_top u_tts_top (.ref_clk_i, .rst_b_i, .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdat), .avs_waitrequest_o(wq),
    .dig_pin_i(pin), .fp_imm_trig_i(fp), .level_o(lv), .initiated_o(ini),
    .trigger_output_pin_o(trigger_output_pin));
  tts_pin_model u_tts_pin_model (.clk_i(ref_clk_i), .fire_i(fire), .idx_i(fidx), .pin_o(pin));
  always #50 ref_clk_i = ~ref_clk_i;
  // Trigger-out pulses last one cycle, so they are counted as they pass
  always @(posedge ref_clk_i) begin
    if (rst_b_i) begin
      tseen <= tseen | trigger_output_pin;
      tc0 <= tc0 + {7'h0, trigger_output_pin[0]};
    end
  end
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      finish_test();
    end
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic tts_level_t nxt(tts_level_t o, logic [31:0] p, logic [7:0] c);
    nxt = o;
    if (c[5]) nxt.volt = p[15:0];
    if (c[6]) nxt.curr = p[31:16];
  endfunction : nxt
  function automatic logic [5:0] ra(logic [1:0] g, int c);
    return {g, c[1:0], 2'h0};
  endfunction : ra
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    wr <= w;
    rd <= ~w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge ref_clk_i);
    end while (wq !== 1'b0);
    rq = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge ref_clk_i);
  endtask : bus
  task automatic cmd(input logic [2:0] op, input logic [3:0] m);
    bus(1'b1, `TTS_OFS_CMD, {25'h0, op, m});
    repeat (12) @(posedge ref_clk_i);
  endtask : cmd
  task automatic pulse(input logic [2:0] i);
    fidx <= i;
    fire <= 1'b1;
    @(posedge ref_clk_i);
    fire <= 1'b0;
    repeat (12) @(posedge ref_clk_i);
  endtask : pulse
  task automatic check(input logic [3:0] busy);
    bus(1'b0, `TTS_OFS_STATUS, '0);
    `CHK(rq[3:0], busy)
    `CHK(ini, busy)
    for (int c = 0; c < 4; c++) `CHK(lv[c], ex[c])
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (5) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    for (int c = 0; c < 4; c++) begin
      ex[c] = '0;
      pl[c] = rnd();
    end
    check(4'h0);
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, ra(`TTS_GRP_CFG, c), {24'h0, cf[8*c+:8]});
      bus(1'b1, ra(`TTS_GRP_LVL, c), pl[c]);
      bus(1'b0, ra(`TTS_GRP_CFG, c), '0);
      `CHK(rq, {24'h0, cf[8*c+:8]})
      bus(1'b0, ra(`TTS_GRP_LVL, c), '0);
      `CHK(rq, pl[c])
    end
    bus(1'b0, 6'h3c, '0);
    `CHK(rq, 32'h0000_0000)
    bus(1'b0, `TTS_OFS_CMD, '0);
    `CHK(rq, 32'h0000_0000)
    $display("T1 config done");
    cmd(`TTS_OP_BUS, 4'hf);
    cmd(`TTS_OP_IMM, 4'hf);
    check(4'h0);
    cmd(`TTS_OP_INIT, 4'hf);
    cmd(`TTS_OP_INIT, 4'hf);
    pulse(3'h4);
    repeat (100) @(posedge ref_clk_i);
    check(4'hf);
    $display("T2 wait done");
    cmd(`TTS_OP_BUS, 4'hf);
    ex[0] = nxt(ex[0], pl[0], cf[7:0]);
    ex[2] = nxt(ex[2], pl[2], cf[23:16]);
    check(4'h8);
    `CHK(tseen, 4'h1)
    `CHK(tc0, 8'h01)
    pulse(3'h5);
    ex[3] = nxt(ex[3], pl[3], cf[31:24]);
    check(4'h0);
    $display("T3 sources done");
    for (int c = 2; c < 4; c++) begin
      pl[c] = rnd();
      bus(1'b1, ra(`TTS_GRP_LVL, c), pl[c]);
      ex[c] = nxt(ex[c], pl[c], cf[8*c+:8]);
    end
    cmd(`TTS_OP_INIT, 4'hc);
    fp <= 4'h8;
    repeat (4) @(posedge ref_clk_i);
    fp <= 4'h0;
    cmd(`TTS_OP_IMM, 4'h4);
    check(4'h0);
    $display("T4 immediate done");
    cmd(`TTS_OP_INIT, 4'hf);
    cmd(`TTS_OP_ABORT, 4'h5);
    check(4'ha);
    cmd(`TTS_OP_ABORT, 4'ha);
    cmd(`TTS_OP_BUS, 4'hf);
    pulse(3'h5);
    check(4'h0);
    `CHK(tseen, 4'h1)
    `CHK(tc0, 8'h01)
    $display("T5 abort done");
    finish_test();
  end
endmodule : transient_trigger_sequencer_test
